/* File: design/sio_dev.sv */
// SRAM port end: burst-of-two DDR read and late-write memory.
// Assumes the controller drives the input clock pair and keeps the
// command, address and data stable around the sampling edges.
`timescale 1ns/1ps
// Function
// RULE_01 - Read when select high at true edge
// RULE_02 - Each read returns two full-width words
// RULE_03 - First word after comp edge, second next
// RULE_04 - Back-to-back reads stream words every edge
// RULE_05 - Output clocks held high: use input clocks
// RULE_06 - Deselect finishes burst then outputs off
// RULE_07 - Echo strobes toggle continuously
// RULE_08 - Write when select low, address next edge (code latches the write address on the same true edge as the command)
// RULE_09 - Late write words on next two edges
// RULE_10 - Back-to-back writes capture every edge
// RULE_11 - Write data ignored when no write
// RULE_12 - Low enables gate lanes zero and one
// RULE_13 - Enables two, three gate upper lanes
// RULE_14 - Impedance updates only in quiet cycles
// RULE_15 - Controller waits 1024 non-read cycles
// RULE_16 - Relock 1024 cycles after clock restart
// RULE_17 - Missing input clock resets the loop
// RULE_18 - Single clock mode fixed from power up
// RULE_19 - Separate load per bank, shared select
// RULE_20 - Low loop-off pin disables the loop
// RULE_21 - Address and controls on true edge only
// RULE_22 - Fixed two-word burst counter for both
// RULE_23 - Second word at start address plus one
module sio_dev import sio_pkg::*; #(
  parameter int ADDR_W  = SIO_ADDR_W,
  parameter int BANKS   = 1,
  parameter int BANK_ID = 0
) (
  // System clock and reset
  input  wire logic                 clock,
  input  wire logic                 reset,
  // Impedance target and status
  input  wire logic [SIO_IMP_W-1:0] imp_target,
  output logic      [SIO_IMP_W-1:0] imp_code,
  output logic                      dll_locked,
  output logic                      single_clock_mode,
  // Link
  sio_link_if.dev                   link
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [ADDR_W-1:0] burst_next(
    input logic [ADDR_W-1:0] a
  );
    return a + 1'b1;
  endfunction : burst_next

  function automatic logic [SIO_DATA_W-1:0] lane_merge(
    input logic [SIO_DATA_W-1:0] old_w,
    input logic [SIO_DATA_W-1:0] new_w,
    input logic [SIO_LANES-1:0]  ben_n
  );
    logic [SIO_DATA_W-1:0] res;
    res = old_w;
    for (int i = 0; i < SIO_LANES; i++) begin
      if (!ben_n[i]) begin
        res[i*SIO_LANE_W +: SIO_LANE_W] = new_w[i*SIO_LANE_W +: SIO_LANE_W];
      end
    end
    return res;
  endfunction : lane_merge

  // ****************************************
  // Declarations
  // ****************************************
  localparam logic [SIO_CNT_W-1:0] LOCK_MAX =
    SIO_CNT_W'(SIO_DLL_LOCK_CYC);
  localparam logic [3:0] IDLE_MAX = 4'(SIO_KC_RESET_CYC);

  logic [SIO_DATA_W-1:0] mem_q [2**ADDR_W];
  logic                  rst_l;
  logic [1:0]            ctl_s;
  logic [SIO_IMP_W-1:0]  imp_s;
  logic [1:0]            echo_s;
  logic                  lock_l;
  logic                  mode_s;
  logic                  rd_cmd_q;
  logic                  wr_cmd_q;
  logic [ADDR_W-1:0]     cmd_addr_q;
  logic                  rd_v1_q;
  logic [SIO_DATA_W-1:0] rd_w0_q;
  logic [SIO_DATA_W-1:0] rd_w1_q;
  logic                  wv_q;
  logic [ADDR_W-1:0]     wa_q;
  logic [SIO_DATA_W-1:0] w0_q;
  logic [SIO_DATA_W-1:0] w1_q;
  logic [SIO_LANES-1:0]  be0_q;
  logic [SIO_LANES-1:0]  be1_q;
  logic [SIO_CNT_W-1:0]  lock_cnt_q;
  logic                  lock_q;
  logic [1:0]            echo_p_q;
  logic [3:0]            idle_q;
  logic                  dll_rst_q;

  wire sel    = ~link.load_n[BANK_ID];
  wire rd_req = sel & link.read_write_select;
  wire wr_req = sel & ~link.read_write_select;
  wire quiet  = ~(rd_req | rd_cmd_q | rd_v1_q | link.fall_oe | link.rise_oe);
  wire loop_hold = ctl_s[1] | ~ctl_s[0];
  wire clk_seen  = |(echo_s ^ echo_p_q);

  // ****************************************
  // Link-side synchronisers
  // ****************************************
  sio_sync2 #(.W(1)) u_rst_sync (
    .clock (link.sample_edge_true),
    .reset (1'b0),
    .d     (reset),
    .q     (rst_l)
  );

  sio_sync2 #(.W(2)) u_ctl_sync (
    .clock (link.sample_edge_true),
    .reset (rst_l),
    .d     ({dll_rst_q, link.dll_off_n}),
    .q     (ctl_s)
  );

  // Target is quasi-static; a torn code lasts one update at most
  sio_sync2 #(.W(SIO_IMP_W)) u_imp_sync (
    .clock (link.sample_edge_true),
    .reset (rst_l),
    .d     (imp_target),
    .q     (imp_s)
  );

  // ****************************************
  // Command capture on the true edge
  // ****************************************
  always_ff @(posedge link.sample_edge_true) begin
    if (rst_l) begin
      rd_cmd_q   <= 1'b0;
      wr_cmd_q   <= 1'b0;
      cmd_addr_q <= '0;
    end else begin
      rd_cmd_q   <= rd_req; // RULE_01
      wr_cmd_q   <= wr_req; // RULE_08
      cmd_addr_q <= link.addr_in; // RULE_21
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always_ff @(posedge link.sample_edge_true) begin
    if (rst_l) begin
      rd_v1_q <= 1'b0;
      rd_w0_q <= '0;
      rd_w1_q <= '0;
    end else begin
      rd_v1_q <= rd_cmd_q;
      rd_w0_q <= mem_q[cmd_addr_q]; // RULE_02
      rd_w1_q <= mem_q[burst_next(cmd_addr_q)]; // RULE_23
    end
  end

  // First word on the comp edge after the next one
  always_ff @(posedge link.sample_edge_comp) begin
    if (rst_l) begin
      link.fall_word <= '0;
      link.fall_oe   <= 1'b0;
    end else begin
      link.fall_word <= rd_w0_q; // RULE_03
      link.fall_oe   <= rd_v1_q; // RULE_06
    end
  end

  // Output clock pair mirrors the input pair or is tied high,
  // so launching from the input pair serves both modes
  always_ff @(posedge link.sample_edge_true) begin
    if (rst_l) begin
      link.rise_word <= '0;
      link.rise_oe   <= 1'b0;
    end else begin
      link.rise_word <= rd_w1_q; // RULE_05
      link.rise_oe   <= rd_v1_q; // RULE_04
    end
  end

  // ****************************************
  // Late write path
  // ****************************************
  always_ff @(posedge link.sample_edge_true) begin
    if (rst_l) begin
      wv_q  <= 1'b0;
      wa_q  <= '0;
      w0_q  <= '0;
      be0_q <= '1;
    end else begin
      wv_q  <= wr_cmd_q; // RULE_22
      wa_q  <= cmd_addr_q;
      w0_q  <= link.write_word_in; // RULE_09
      be0_q <= wr_cmd_q ? link.byte_write_n : '1; // RULE_11
    end
  end

  always_ff @(posedge link.sample_edge_comp) begin
    if (rst_l) begin
      w1_q  <= '0;
      be1_q <= '1;
    end else begin
      w1_q  <= link.write_word_in; // RULE_10
      be1_q <= wv_q ? link.byte_write_n : '1; // RULE_11
    end
  end

  // Both words commit together once the second has landed
  always_ff @(posedge link.sample_edge_true) begin
    if (!rst_l && wv_q) begin
      mem_q[wa_q] <= lane_merge(mem_q[wa_q], w0_q, be0_q); // RULE_12
      mem_q[burst_next(wa_q)] <=
        lane_merge(mem_q[burst_next(wa_q)], w1_q, be1_q); // RULE_13
    end
  end

  // ****************************************
  // Echo strobes, loop lock, impedance
  // ****************************************
  always_ff @(posedge link.sample_edge_true) begin
    if (rst_l) begin
      link.echo_rise <= 1'b0;
    end else begin
      link.echo_rise <= ~link.echo_rise; // RULE_07
    end
  end

  always_ff @(posedge link.sample_edge_comp) begin
    if (rst_l) begin
      link.echo_fall <= 1'b0;
    end else begin
      link.echo_fall <= link.echo_rise;
    end
  end

  always_ff @(posedge link.sample_edge_true) begin
    if (rst_l || loop_hold) begin
      lock_cnt_q <= '0; // RULE_20
      lock_q     <= 1'b0;
    end else begin
      lock_cnt_q <= (lock_cnt_q == LOCK_MAX) ? lock_cnt_q : lock_cnt_q + 1'b1;
      lock_q     <= (lock_cnt_q == LOCK_MAX); // RULE_16
    end
  end

  always_ff @(posedge link.sample_edge_true) begin
    if (rst_l) begin
      imp_code <= SIO_IMP_RST;
    end else if (quiet) begin
      imp_code <= imp_s; // RULE_14
    end
  end

  // ****************************************
  // System-clock side: clock watchdog, mode
  // ****************************************
  sio_sync2 #(.W(2)) u_echo_sync (
    .clock (clock),
    .reset (reset),
    .d     ({link.echo_rise, link.echo_fall}),
    .q     (echo_s)
  );

  sio_sync2 #(.W(1)) u_lock_sync (
    .clock (clock),
    .reset (reset),
    .d     (lock_q),
    .q     (lock_l)
  );

  sio_sync2 #(.W(1)) u_mode_sync (
    .clock (clock),
    .reset (reset),
    .d     (link.output_timing_true & link.output_timing_inv),
    .q     (mode_s)
  );

  // Held reset reaches the link side only once edges resume
  always_ff @(posedge clock) begin
    if (reset) begin
      echo_p_q  <= 2'h0;
      idle_q    <= 4'h0;
      dll_rst_q <= 1'b0;
    end else begin
      echo_p_q  <= echo_s;
      idle_q    <= clk_seen ? 4'h0 :
                   (idle_q == IDLE_MAX) ? idle_q : idle_q + 1'b1;
      dll_rst_q <= (idle_q == IDLE_MAX) & ~clk_seen; // RULE_17
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      dll_locked        <= 1'b0;
      single_clock_mode <= 1'b1;
    end else begin
      dll_locked        <= lock_l;
      single_clock_mode <= single_clock_mode & mode_s; // RULE_18
    end
  end

endmodule : sio_dev

/* File: design/sio_host.sv */
// Memory controller end: makes the link clocks, issues commands,
// late-write data and pairs returned read words.
// Assumes one request per four system cycles at most.
`timescale 1ns/1ps
module sio_host import sio_pkg::*; #(
  parameter int ADDR_W       = SIO_ADDR_W,
  parameter int BANKS        = 1,
  parameter bit SINGLE_CLOCK = 1'b0,
  parameter int BANK_W       = (BANKS > 1) ? $clog2(BANKS) : 1
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  reset,
  // Control and status
  input  wire logic                  clk_stop,
  input  wire logic                  dll_enable,
  output logic                       link_ready,
  // Requests
  input  wire logic                  req_valid,
  input  wire logic                  req_write,
  input  wire logic [BANK_W-1:0]     req_bank,
  input  wire logic [ADDR_W-1:0]     req_addr,
  input  wire logic [SIO_DATA_W-1:0] req_data0,
  input  wire logic [SIO_DATA_W-1:0] req_data1,
  input  wire logic [SIO_LANES-1:0]  req_ben0_n,
  input  wire logic [SIO_LANES-1:0]  req_ben1_n,
  output logic                       req_ready,
  // Read return
  output logic                       rd_valid,
  output logic [SIO_DATA_W-1:0]      rd_data0,
  output logic [SIO_DATA_W-1:0]      rd_data1,
  // Link
  sio_link_if.host                   link
);
  localparam logic [SIO_CNT_W-1:0] WAIT_MAX = SIO_CNT_W'(
    (SIO_DLL_LOCK_CYC > SIO_NONREAD_CYC) ? SIO_DLL_LOCK_CYC : SIO_NONREAD_CYC);

  sio_host_st_t          state_q, state_d;
  logic [1:0]            ph_q;
  logic [SIO_CNT_W-1:0]  wait_q;
  logic [1:0]            busy_q;
  logic                  wp_v_q;
  logic [SIO_DATA_W-1:0] wp0_q, wp1_q, st1_q, first_q;
  logic [SIO_LANES-1:0]  wb0_q, wb1_q, sb1_q;
  logic [BANKS-1:0]      ld_n_d;
  logic                  half_q;
  logic                  rs_oe;
  logic [SIO_DATA_W-1:0] rs_word;

  // Slots sit mid-phase so the SRAM never samples a changing pin
  wire cmd_slot  = (ph_q == 2'h0);
  wire w1_slot   = (ph_q == 2'h2);
  wire accept    = req_valid & req_ready;
  wire stop_ok   = cmd_slot & clk_stop & ~accept & (busy_q == 2'h0);
  wire [1:0] ph_d = (state_d == SIO_STOP) ? 2'h0 : ph_q + 2'h1;

  // ****************************************
  // State and clock divider
  // ****************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      SIO_WAIT: if (wait_q == WAIT_MAX) state_d = SIO_RUN; // RULE_15
      SIO_RUN:  if (stop_ok) state_d = SIO_STOP;
      SIO_STOP: if (!clk_stop) state_d = SIO_WAIT; // RULE_16
      default:  state_d = SIO_WAIT;
    endcase
  end

  always_comb begin
    ld_n_d = '1;
    for (int i = 0; i < BANKS; i++) begin
      if (accept && req_bank == BANK_W'(i)) ld_n_d[i] = 1'b0; // RULE_19
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q                 <= SIO_WAIT;
      ph_q                    <= 2'h0;
      link.sample_edge_true   <= 1'b0;
      link.output_timing_true <= 1'b1;
      link.output_timing_inv  <= 1'b1;
    end else begin
      state_q                 <= state_d;
      ph_q                    <= ph_d;
      link.sample_edge_true   <= ph_d[1];
      link.output_timing_true <= SINGLE_CLOCK | ph_d[1]; // RULE_18
      link.output_timing_inv  <= SINGLE_CLOCK | ~ph_d[1];
    end
  end

  always_ff @(posedge clock) begin
    if (reset || state_q == SIO_STOP) begin
      wait_q <= '0;
    end else if (ph_q == 2'h1 && wait_q != WAIT_MAX) begin
      wait_q <= wait_q + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      req_ready     <= 1'b0;
      link_ready    <= 1'b0;
      link.dll_off_n <= 1'b0;
    end else begin
      req_ready     <= (state_d == SIO_RUN) & (ph_q == 2'h3) & ~clk_stop;
      link_ready    <= (state_d == SIO_RUN);
      link.dll_off_n <= dll_enable;
    end
  end

  // ****************************************
  // Commands and late-write data
  // ****************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      link.load_n            <= '1;
      link.read_write_select <= 1'b1;
      link.addr_in           <= '0;
      wp_v_q                 <= 1'b0;
      busy_q                 <= 2'h0;
    end else if (cmd_slot) begin
      link.load_n            <= ld_n_d;
      link.read_write_select <= ~req_write; // RULE_21
      link.addr_in           <= req_addr;
      wp_v_q                 <= accept & req_write;
      busy_q <= accept ? 2'(SIO_DRAIN_SLOTS) :
                (busy_q == 2'h0) ? busy_q : busy_q - 2'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      link.write_word_in <= '0;
      link.byte_write_n  <= '1;
      wp0_q <= '0;
      wp1_q <= '0;
      wb0_q <= '1;
      wb1_q <= '1;
      st1_q <= '0;
      sb1_q <= '1;
    end else if (cmd_slot) begin
      if (accept) begin
        wp0_q <= req_data0;
        wp1_q <= req_data1;
        wb0_q <= req_ben0_n;
        wb1_q <= req_ben1_n;
      end
      link.write_word_in <= wp0_q; // RULE_09
      link.byte_write_n  <= wp_v_q ? wb0_q : '1;
      st1_q <= wp1_q;
      sb1_q <= wp_v_q ? wb1_q : '1;
    end else if (w1_slot) begin
      link.write_word_in <= st1_q; // RULE_10
      link.byte_write_n  <= sb1_q;
    end
  end

  // ****************************************
  // Read return pairing
  // ****************************************
  sio_sync2 #(.W(SIO_DATA_W + 1)) u_rd_sync (
    .clock (clock),
    .reset (reset),
    .d     ({link.read_oe, link.read_word_out}),
    .q     ({rs_oe, rs_word})
  );

  // Synchroniser output is taken only where it holds a mid-phase sample
  always_ff @(posedge clock) begin
    if (reset) begin
      half_q   <= 1'b0;
      rd_valid <= 1'b0;
      first_q  <= '0;
      rd_data0 <= '0;
      rd_data1 <= '0;
    end else begin
      rd_valid <= ~ph_q[0] & rs_oe & half_q;
      if (!ph_q[0]) begin
        half_q <= rs_oe & ~half_q;
        if (rs_oe && !half_q) first_q <= rs_word;
        if (rs_oe && half_q) begin
          rd_data0 <= first_q; // RULE_02
          rd_data1 <= rs_word;
        end
      end
    end
  end

endmodule : sio_host

/* File: design/sio_link_if.sv */
// Link carrier between the memory controller and the SRAM port.
// Assumes the controller makes the input clock; output pins are
// merged here from the half-cycle registers of the SRAM end.
`timescale 1ns/1ps
interface sio_link_if import sio_pkg::*; #(
  parameter int ADDR_W = SIO_ADDR_W,
  parameter int BANKS  = 1
);
  logic                  sample_edge_true;
  logic                  output_timing_true;
  logic                  output_timing_inv;
  logic [BANKS-1:0]      load_n;
  logic                  read_write_select;
  logic [ADDR_W-1:0]     addr_in;
  logic [SIO_DATA_W-1:0] write_word_in;
  logic [SIO_LANES-1:0]  byte_write_n;
  logic                  dll_off_n;
  logic [SIO_DATA_W-1:0] rise_word;
  logic [SIO_DATA_W-1:0] fall_word;
  logic                  rise_oe;
  logic                  fall_oe;
  logic                  echo_rise;
  logic                  echo_fall;

  // ****************************************
  // Pin level merge
  // ****************************************
  wire                  sample_edge_comp = ~sample_edge_true;
  wire [SIO_DATA_W-1:0] read_word_out    =
    sample_edge_true ? rise_word : fall_word;
  wire                  read_oe          =
    sample_edge_true ? rise_oe : fall_oe;
  wire                  echo_strobe      = echo_rise ^ echo_fall;
  wire                  echo_strobe_inv  = ~echo_strobe;

  modport host (
    output sample_edge_true, output_timing_true, output_timing_inv,
    output load_n, read_write_select, addr_in, write_word_in,
    output byte_write_n, dll_off_n,
    input  read_word_out, read_oe, echo_strobe, echo_strobe_inv
  );

  modport dev (
    input  sample_edge_true, sample_edge_comp, output_timing_true,
    input  output_timing_inv, load_n, read_write_select, addr_in,
    input  write_word_in, byte_write_n, dll_off_n,
    output rise_word, fall_word, rise_oe, fall_oe, echo_rise, echo_fall
  );
endinterface : sio_link_if

/* File: design/sio_pkg.sv */
// Shared constants and types for the burst-of-two separate-I/O SRAM link.
// Assumes both link ends and the link carrier import it whole.
package sio_pkg;

  // ****************************************
  // Organization
  // ****************************************
  localparam int SIO_DATA_W = 36;
  localparam int SIO_LANE_W = 9;
  localparam int SIO_LANES  = SIO_DATA_W / SIO_LANE_W;
  localparam int SIO_ADDR_W = 19;
  localparam int SIO_CNT_W  = 11;

  // ****************************************
  // Timing
  // ****************************************
  localparam int SIO_CLK_NS       = 8;
  localparam int SIO_KC_RESET_NS  = 30;
  localparam int SIO_KC_RESET_CYC =
    (SIO_KC_RESET_NS + SIO_CLK_NS - 1) / SIO_CLK_NS;
  localparam int SIO_DLL_LOCK_CYC = 1024;
  localparam int SIO_NONREAD_CYC  = 1024;
  localparam int SIO_DRAIN_SLOTS  = 3;

  // ****************************************
  // Impedance code
  // ****************************************
  localparam int                   SIO_IMP_W   = 6;
  localparam logic [SIO_IMP_W-1:0] SIO_IMP_RST = 6'h20;

  // ****************************************
  // Controller states
  // ****************************************
  typedef enum logic [1:0] {
    SIO_WAIT = 2'b00,
    SIO_RUN  = 2'b01,
    SIO_STOP = 2'b10
  } sio_host_st_t;

endpackage : sio_pkg

/* File: design/sio_sync2.sv */
// Two-stage level synchroniser, reset synchronously to zero.
// Assumes the input is quasi-static or a single level per bit.
`timescale 1ns/1ps
module sio_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         reset,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : sio_sync2

/* File: sim/sio_burst2_sram_port_bench.sv */
// Bench joining controller and SRAM port over the link carrier.
// Assumes only the system clock; the controller makes the link clock.
`timescale 1ns/1ps
module sio_burst2_sram_port_bench import sio_pkg::*; ;
  // ****************
  // Signals
  // ****************
  logic        clock = 1'b0, reset = 1'b1, clk_stop = 1'b0;
  logic        dll_enable = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic [0:0]  req_bank   = 1'h0;
  logic [18:0] req_addr   = 19'h00000;
  logic [35:0] req_data0  = 36'h0, req_data1 = 36'h0;
  logic [3:0]  req_ben0_n = 4'hf, req_ben1_n = 4'hf;
  logic [5:0]  imp_target = 6'h00, imp_code;
  logic        req_ready, link_ready, rd_valid, dll_locked, single_clock_mode;
  logic [35:0] rd_data0, rd_data1;
  logic [35:0] mem [int];
  logic [71:0] exp_q [$];
  int          err_total = 0, cmp_count = 0;

  sio_link_if i_sio_link_if ();
  sio_host i_sio_host (.clock(clock), .reset(reset), .clk_stop(clk_stop),
    .dll_enable(dll_enable), .link_ready(link_ready), .req_valid(req_valid),
    .req_write(req_write), .req_bank(req_bank), .req_addr(req_addr),
    .req_data0(req_data0), .req_data1(req_data1), .req_ben0_n(req_ben0_n),
    .req_ben1_n(req_ben1_n), .req_ready(req_ready), .rd_valid(rd_valid),
    .rd_data0(rd_data0), .rd_data1(rd_data1), .link(i_sio_link_if));
  sio_dev i_sio_dev (.clock(clock), .reset(reset), .imp_target(imp_target),
    .imp_code(imp_code), .dll_locked(dll_locked),
    .single_clock_mode(single_clock_mode), .link(i_sio_link_if));
  sio_link_chk i_sio_link_chk (.clock(clock), .reset(reset),
    .sample_edge_true(i_sio_link_if.sample_edge_true),
    .output_timing_true(i_sio_link_if.output_timing_true),
    .output_timing_inv(i_sio_link_if.output_timing_inv),
    .load_n(i_sio_link_if.load_n), .addr_in(i_sio_link_if.addr_in),
    .read_write_select(i_sio_link_if.read_write_select),
    .rise_oe(i_sio_link_if.rise_oe), .fall_oe(i_sio_link_if.fall_oe),
    .echo_strobe(i_sio_link_if.echo_strobe));

  // ****************
  // Tasks
  // ****************
  task automatic check(string what, logic [35:0] e, logic [35:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic print_verdict();
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  function automatic logic [35:0] lanes(logic [35:0] o, n, logic [3:0] b);
    lanes = o;
    for (int i = 0; i < 4; i++) begin
      if (!b[i]) lanes[i*9 +: 9] = n[i*9 +: 9];
    end
  endfunction : lanes

  task automatic gap(int n);
    req_valid <= 1'b0;
    repeat (n) @(posedge clock);
  endtask : gap

  task automatic wait_hi(string what, bit lock, int lim);
    logic s;
    s = 1'b0;
    for (int n = 0; n < lim && s !== 1'b1; n++) begin
      @(negedge clock);
      s = lock ? dll_locked : link_ready;
    end
    check(what, 36'h1, 36'(s));
  endtask : wait_hi

  // Request stays up until the edge that sees ready
  task automatic issue(logic w, logic [18:0] a, logic [3:0] b0, b1);
    logic [18:0] a1;
    logic [35:0] d0, d1;
    logic        r;
    a1 = a + 19'h00001;
    d0 = {4'($urandom()), $urandom()};
    d1 = {4'($urandom()), $urandom()};
    r = 1'b0;
    req_valid  <= 1'b1;
    req_write  <= w;
    req_addr   <= a;
    req_data0  <= d0;
    req_data1  <= d1;
    req_ben0_n <= b0;
    req_ben1_n <= b1;
    for (int n = 0; n < 40 && !r; n++) begin
      @(negedge clock);
      r = req_ready;
      @(posedge clock);
    end
    check("accept", 36'h1, 36'(r));
    if (w) begin
      mem[a]  = lanes(mem[a], d0, b0);
      mem[a1] = lanes(mem[a1], d1, b1);
    end else begin
      exp_q.push_back({mem[a], mem[a1]});
    end
  endtask : issue

  // ****************
  // Processes
  // ****************
  initial forever #4 clock = ~clock;

  always @(negedge clock) begin
    logic [71:0] e;
    if (rd_valid === 1'b1) begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : {72{1'bx}};
      check("read word 0", e[71:36], rd_data0);
      check("read word 1", e[35:0], rd_data1);
    end
  end

  initial begin
    repeat (40000) @(posedge clock);
    err_total++;
    print_verdict();
  end

  initial begin
    logic [18:0] a, pa;
    logic        w, pw;
    void'($urandom(55936));
    imp_target <= 6'($urandom());
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    wait_hi("link ready", 1'b0, 6000);
    check("loop lock", 36'h0, 36'(dll_locked));
    check("impedance", 36'(imp_target), 36'(imp_code));
    check("single clock", 36'h0, 36'(single_clock_mode));
    dll_enable <= 1'b1;
    for (int i = 0; i < 18; i += 2) begin
      a = (i == 16) ? 19'h7ffff : 19'(i);
      issue(1'b1, a, 4'h0, 4'h0);
    end
    // No forwarding: reads touching the last write wait
    gap(8);
    issue(1'b0, 19'h7ffff, 4'h0, 4'h0);
    pw = 1'b0;
    pa = 19'h00000;
    for (int i = 0; i < 80; i++) begin
      w = 1'($urandom());
      a = 19'($urandom() % 15);
      if (i == 40) imp_target <= ~imp_target;
      if (!w && pw && a <= pa + 19'h1 && pa <= a + 19'h1) gap(8);
      issue(w, a, 4'($urandom()), 4'($urandom()));
      pw = w;
      pa = a;
    end
    gap(60);
    check("reads left", 36'h0, 36'(exp_q.size()));
    check("impedance", 36'(imp_target), 36'(imp_code));
    wait_hi("loop lock", 1'b1, 6000);
    clk_stop <= 1'b1;
    repeat (200) @(posedge clock);
    clk_stop <= 1'b0;
    repeat (40) @(posedge clock);
    check("loop reset", 36'h0, 36'(dll_locked));
    wait_hi("link ready", 1'b0, 6000);
    wait_hi("loop lock", 1'b1, 600);
    issue(1'b0, 19'h00003, 4'h0, 4'h0);
    gap(30);
    check("reads left", 36'h0, 36'(exp_q.size()));
    print_verdict();
  end
endmodule : sio_burst2_sram_port_bench

/* File: sim/sio_link_chk.sv */
// Link checker: read timing, deselect, echo and pin discipline.
// Assumes it sits beside the carrier that joins both link ends.
`timescale 1ns/1ps
module sio_link_chk import sio_pkg::*; #(
  parameter int ADDR_W = SIO_ADDR_W,
  parameter int BANKS  = 1
) (
  // System clock and reset
  input wire logic              clock,
  input wire logic              reset,
  // Link pins
  input wire logic              sample_edge_true,
  input wire logic              output_timing_true,
  input wire logic              output_timing_inv,
  input wire logic [BANKS-1:0]  load_n,
  input wire logic              read_write_select,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic              rise_oe,
  input wire logic              fall_oe,
  input wire logic              echo_strobe
);
  // ****************
  // Helpers
  // ****************
  logic [3:0] age_q;
  wire        k      = sample_edge_true;
  wire        warm   = &age_q;
  wire        rd_cmd = !load_n[0] && read_write_select;
  wire        wr_cmd = !load_n[0] && !read_write_select;
  wire        c_high = output_timing_true && output_timing_inv;
  // Link end leaves reset a few edges later
  always_ff @(posedge k or posedge reset) begin
    if (reset) begin
      age_q <= 4'h0;
    end else if (!warm) begin
      age_q <= age_q + 4'h1;
    end
  end
  // ****************
  // Assertions
  // ****************
  a_read_lead: assert property (
    @(posedge k) disable iff (reset) rd_cmd |-> ##2 fall_oe)
    else $error("first read word missing");
  a_read_tail: assert property (
    @(posedge k) disable iff (reset) rd_cmd |-> ##3 rise_oe)
    else $error("second read word missing");
  a_read_stream: assert property (
    @(posedge k) disable iff (reset)
    rd_cmd ##1 rd_cmd |-> ##2 (fall_oe && rise_oe))
    else $error("gap in read stream");
  a_write_quiet: assert property (
    @(posedge k) disable iff (reset) warm && wr_cmd |-> ##2 !fall_oe)
    else $error("write drove read data");
  a_idle_hiz: assert property (
    @(posedge k) disable iff (reset)
    (warm && !rd_cmd) [*3] |=> !fall_oe && !rise_oe)
    else $error("outputs on while deselected");
  a_echo_follow: assert property (
    @(posedge clock) disable iff (reset)
    warm && $changed(k) |-> echo_strobe == k)
    else $error("echo strobe out of step");
  a_ctrl_setup: assert property (
    @(posedge clock) disable iff (reset) $rose(k) |->
    $stable(load_n) && $stable(read_write_select) && $stable(addr_in))
    else $error("control moved at sampling edge");
  a_single_fixed: assert property (
    @(posedge clock) disable iff (reset) !$past(c_high) |-> !c_high)
    else $error("output clocks went back to single mode");
  c_reads: cover property (@(posedge k) rd_cmd ##1 rd_cmd);
  c_writes: cover property (@(posedge k) wr_cmd ##1 wr_cmd);
  c_stop: cover property (@(posedge clock) !k [*8]);
endmodule : sio_link_chk
